// ==== sac_regs.svh ====
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

`define SAC_ADDR_INPUT_SEL 3'h0
`define SAC_ADDR_CTRL_A 3'h1
`define SAC_ADDR_CTRL_B 3'h2
`define SAC_ADDR_RES_LOW 3'h3
`define SAC_ADDR_RES_HIGH 3'h4

`define SAC_A_ENABLE 7
`define SAC_A_START 6
`define SAC_A_AUTO 5
`define SAC_A_FLAG 4
`define SAC_A_IRQ_EN 3
`define SAC_SEL_LEFT_ADJ 5

`define SAC_RST_BYTE 8'h00
`define SAC_RST_RESULT 10'h000
`define SAC_TRIG_SELF 3'h0

// Half converter cycles from conversion start
`define SAC_HALF_SAMP_NORMAL 6'h03
`define SAC_HALF_DONE_NORMAL 6'h1A
`define SAC_HALF_SAMP_FIRST 6'h1B
`define SAC_HALF_DONE_FIRST 6'h32
`define SAC_HALF_SAMP_AUTO 6'h04
`define SAC_HALF_DONE_AUTO 6'h1B
`endif

// ==== sac_pkg.sv ====
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_WAIT = 2'b01,
    SAC_CONV = 2'b10
  } sac_state_t;
endpackage

// ==== sac_conv_ctrl.sv ====
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "sac_regs.svh"
module sac_conv_ctrl
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_trig,
  input wire logic i_sleep_conv_mode,
  input wire logic i_cpu_halted,
  input wire logic [9:0] i_core_result,
  output logic o_core_enable,
  output logic o_core_init,
  output logic [1:0] o_channel_select,
  output logic [1:0] o_reference_select,
  output logic o_sample_hold,
  output logic o_conv_busy,
  output logic o_conversion_done_flag
);

  sac_pkg::sac_state_t state;
  sac_pkg::sac_state_t next_state;
  logic [7:0] input_select_reg;
  logic [7:0] next_input_select_reg;
  logic conv_enable;
  logic next_conv_enable;
  logic start_conversion;
  logic next_start_conversion;
  logic auto_trigger_enable;
  logic next_auto_trigger_enable;
  logic done_irq_enable;
  logic next_done_irq_enable;
  logic [2:0] clock_divider_select;
  logic [2:0] next_clock_divider_select;
  logic [2:0] trigger_source_select;
  logic [2:0] next_trigger_source_select;
  logic [9:0] result;
  logic [9:0] next_result;
  logic locked;
  logic next_locked;
  logic first_run;
  logic next_first_run;
  logic [7:0] presc;
  logic [7:0] next_presc;
  logic [5:0] hcnt;
  logic [5:0] next_hcnt;
  logic [5:0] samp_at;
  logic [5:0] next_samp_at;
  logic [5:0] done_at;
  logic [5:0] next_done_at;
  logic [3:0] trig_d;
  logic [3:0] next_trig_d;
  logic halted_d;
  logic [7:0] next_rdata;
  logic next_core_init;
  logic [1:0] next_channel_select;
  logic [1:0] next_reference_select;
  logic next_sample_hold;
  logic next_conv_busy;
  logic next_done_flag;

  logic [7:0] mask;
  logic tick_full;
  logic tick_half;
  logic [5:0] hcnt_inc;
  logic trig_rise;
  logic free_run;
  logic done_now;
  logic sw_start;
  logic sleep_start;
  logic [7:0] low_byte;
  logic [7:0] high_byte;

  // Power-of-two divider, period 2 to 256 cycles
  assign mask = 8'((16'h0002 << clock_divider_select) - 16'h0001);
  assign tick_full = ((presc & mask) == mask);
  assign tick_half = tick_full || ((presc & mask) == (mask >> 1));
  assign hcnt_inc = 6'(hcnt + 6'h01);
  // Three-cycle delayed trigger, edge only
  assign trig_rise = trig_d[2] & ~trig_d[3];
  assign free_run = auto_trigger_enable && (trigger_source_select == `SAC_TRIG_SELF);
  assign done_now = (state == sac_pkg::SAC_CONV) && tick_half && (hcnt_inc == done_at);
  assign sw_start = i_wr && (i_addr == `SAC_ADDR_CTRL_A) && i_wdata[`SAC_A_START];
  assign sleep_start = i_cpu_halted && !halted_d && i_sleep_conv_mode
    && !auto_trigger_enable && done_irq_enable;
  assign low_byte = input_select_reg[`SAC_SEL_LEFT_ADJ] ? {result[1:0], 6'h00}
    : result[7:0];
  assign high_byte = input_select_reg[`SAC_SEL_LEFT_ADJ] ? result[9:2]
    : {6'h00, result[9:8]};

  always_comb
  begin
    next_state = state;
    next_input_select_reg = input_select_reg;
    next_conv_enable = conv_enable;
    next_start_conversion = start_conversion;
    next_auto_trigger_enable = auto_trigger_enable;
    next_done_irq_enable = done_irq_enable;
    next_clock_divider_select = clock_divider_select;
    next_trigger_source_select = trigger_source_select;
    next_result = result;
    next_locked = locked;
    next_first_run = first_run;
    next_presc = 8'(presc + 8'h01);
    next_hcnt = hcnt;
    next_samp_at = samp_at;
    next_done_at = done_at;
    next_trig_d = {trig_d[2:0], i_trig[trigger_source_select]};
    next_rdata = 8'h00;
    next_done_flag = o_conversion_done_flag;
    next_sample_hold = 1'b0;

    if (i_wr)
    begin
      case (i_addr)
        `SAC_ADDR_INPUT_SEL: next_input_select_reg = i_wdata;
        `SAC_ADDR_CTRL_A:
        begin
          next_conv_enable = i_wdata[`SAC_A_ENABLE];
          next_auto_trigger_enable = i_wdata[`SAC_A_AUTO];
          next_done_irq_enable = i_wdata[`SAC_A_IRQ_EN];
          next_clock_divider_select = i_wdata[2:0];
          if (i_wdata[`SAC_A_FLAG])
          begin
            next_done_flag = 1'b0;
          end
        end
        `SAC_ADDR_CTRL_B: next_trigger_source_select = i_wdata[2:0];
        default: ;
      endcase
    end

    if (i_rd)
    begin
      case (i_addr)
        `SAC_ADDR_INPUT_SEL: next_rdata = input_select_reg;
        `SAC_ADDR_CTRL_A: next_rdata = {conv_enable, start_conversion, auto_trigger_enable,
          o_conversion_done_flag, done_irq_enable, clock_divider_select};
        `SAC_ADDR_CTRL_B: next_rdata = {5'h00, trigger_source_select};
        `SAC_ADDR_RES_LOW:
        begin
          next_rdata = low_byte;
          next_locked = 1'b1;
        end
        `SAC_ADDR_RES_HIGH:
        begin
          next_rdata = high_byte;
          next_locked = 1'b0;
        end
        default: next_rdata = 8'h00;
      endcase
    end

    case (state)
      sac_pkg::SAC_IDLE:
      begin
        if (sw_start || sleep_start)
        begin
          next_state = sac_pkg::SAC_WAIT;
          next_start_conversion = 1'b1;
        end
        else if (auto_trigger_enable && !free_run && trig_rise)
        begin
          next_state = sac_pkg::SAC_CONV;
          next_start_conversion = 1'b1;
          next_presc = 8'h00;
          next_hcnt = 6'h00;
          next_samp_at = first_run ? `SAC_HALF_SAMP_FIRST : `SAC_HALF_SAMP_AUTO;
          next_done_at = first_run ? `SAC_HALF_DONE_FIRST : `SAC_HALF_DONE_AUTO;
        end
      end
      sac_pkg::SAC_WAIT:
      begin
        if (tick_full)
        begin
          next_state = sac_pkg::SAC_CONV;
          next_hcnt = 6'h00;
          next_samp_at = first_run ? `SAC_HALF_SAMP_FIRST : `SAC_HALF_SAMP_NORMAL;
          next_done_at = first_run ? `SAC_HALF_DONE_FIRST : `SAC_HALF_DONE_NORMAL;
        end
      end
      sac_pkg::SAC_CONV:
      begin
        if (tick_half)
        begin
          next_hcnt = hcnt_inc;
          next_sample_hold = (hcnt_inc == samp_at);
        end
        if (done_now)
        begin
          next_done_flag = 1'b1;
          next_first_run = 1'b0;
          if (!locked)
          begin
            next_result = i_core_result;
          end
          if (free_run)
          begin
            next_hcnt = 6'h00;
            next_samp_at = `SAC_HALF_SAMP_NORMAL;
            next_done_at = `SAC_HALF_DONE_NORMAL;
          end
          else
          begin
            next_state = sac_pkg::SAC_IDLE;
            next_start_conversion = 1'b0;
          end
        end
      end
      default: next_state = sac_pkg::SAC_IDLE;
    endcase

    if (!next_conv_enable)
    begin
      next_state = sac_pkg::SAC_IDLE;
      next_start_conversion = 1'b0;
      next_presc = 8'h00;
      next_first_run = 1'b1;
      next_sample_hold = 1'b0;
    end

    next_channel_select = o_channel_select;
    next_reference_select = o_reference_select;
    // Buffer tracks while enabled and not converting, or in the last converter cycle
    if (conv_enable && (state != sac_pkg::SAC_CONV
      || 7'(hcnt) + 7'h02 >= 7'(done_at)))
    begin
      next_channel_select = input_select_reg[1:0];
      next_reference_select = input_select_reg[7:6];
    end
    next_conv_busy = (next_state == sac_pkg::SAC_CONV);
    next_core_init = next_first_run;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= sac_pkg::SAC_IDLE;
      input_select_reg <= `SAC_RST_BYTE;
      conv_enable <= 1'b0;
      start_conversion <= 1'b0;
      auto_trigger_enable <= 1'b0;
      done_irq_enable <= 1'b0;
      clock_divider_select <= 3'h0;
      trigger_source_select <= 3'h0;
      result <= `SAC_RST_RESULT;
      locked <= 1'b0;
      first_run <= 1'b1;
      presc <= 8'h00;
      hcnt <= 6'h00;
      samp_at <= `SAC_HALF_SAMP_NORMAL;
      done_at <= `SAC_HALF_DONE_NORMAL;
      trig_d <= 4'h0;
      halted_d <= 1'b0;
      o_rdata <= `SAC_RST_BYTE;
      o_core_enable <= 1'b0;
      o_core_init <= 1'b1;
      o_channel_select <= 2'h0;
      o_reference_select <= 2'h0;
      o_sample_hold <= 1'b0;
      o_conv_busy <= 1'b0;
      o_conversion_done_flag <= 1'b0;
    end
    else
    begin
      state <= next_state;
      input_select_reg <= next_input_select_reg;
      conv_enable <= next_conv_enable;
      start_conversion <= next_start_conversion;
      auto_trigger_enable <= next_auto_trigger_enable;
      done_irq_enable <= next_done_irq_enable;
      clock_divider_select <= next_clock_divider_select;
      trigger_source_select <= next_trigger_source_select;
      result <= next_result;
      locked <= next_locked;
      first_run <= next_first_run;
      presc <= next_presc;
      hcnt <= next_hcnt;
      samp_at <= next_samp_at;
      done_at <= next_done_at;
      trig_d <= next_trig_d;
      halted_d <= i_cpu_halted;
      o_rdata <= next_rdata;
      o_core_enable <= next_conv_enable;
      o_core_init <= next_core_init;
      o_channel_select <= next_channel_select;
      o_reference_select <= next_reference_select;
      o_sample_hold <= next_sample_hold;
      o_conv_busy <= next_conv_busy;
      o_conversion_done_flag <= next_done_flag;
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  sequence s_done;
    done_now;
  endsequence

  sequence s_trig_start;
    state == sac_pkg::SAC_IDLE && auto_trigger_enable && !free_run && trig_rise && !sw_start
      && !sleep_start && !(i_wr && i_addr == `SAC_ADDR_CTRL_A && !i_wdata[`SAC_A_ENABLE]);
  endsequence

  property p_off_idle;
    !conv_enable |-> !o_conv_busy && presc == 8'h00;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("busy or counting while off");

  property p_lock_hold;
    s_done ##0 locked |=> result == $past(result);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked result overwritten");

  property p_flag_at_done;
    s_done ##0 conv_enable |=> o_conversion_done_flag;
  endproperty
  a_flag_at_done: assert property (p_flag_at_done) else $error("flag missed at done");

  property p_busy_start;
    o_conv_busy |-> start_conversion;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("start low while busy");

  property p_single_clear;
    s_done ##0 !free_run |=> !start_conversion && !o_conv_busy;
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("start kept after single");

  property p_free_again;
    s_done ##0 free_run && conv_enable && !(i_wr && i_addr == `SAC_ADDR_CTRL_A
      && !i_wdata[`SAC_A_ENABLE]) |=> o_conv_busy && start_conversion && hcnt == 6'h00;
  endproperty
  a_free_again: assert property (p_free_again) else $error("free run stopped");

  property p_trig_starts;
    s_trig_start |=> o_conv_busy && presc == 8'h00 ##1 presc == 8'h01;
  endproperty
  a_trig_starts: assert property (p_trig_starts) else $error("trigger edge not taken");

  property p_edge_ignored;
    o_conv_busy && trig_rise && !done_now |=> samp_at == $past(samp_at) && hcnt != 6'h00;
  endproperty
  a_edge_ignored: assert property (p_edge_ignored) else $error("edge restarted");

  property p_sw_edge;
    state == sac_pkg::SAC_WAIT && tick_full && conv_enable && !(i_wr && i_addr ==
      `SAC_ADDR_CTRL_A) |=> o_conv_busy && hcnt == 6'h00 ##1 o_conv_busy;
  endproperty
  a_sw_edge: assert property (p_sw_edge) else $error("software start not on edge");

  property p_mux_locked;
    o_conv_busy && $past(o_conv_busy) && !$past(done_now) && 7'(hcnt) + 7'h03 < 7'(done_at)
      |-> $stable(o_channel_select) && $stable(o_reference_select);
  endproperty
  a_mux_locked: assert property (p_mux_locked) else $error("selection moved mid conversion");

  property p_core_en;
    o_core_enable == conv_enable;
  endproperty
  a_core_en: assert property (p_core_en) else $error("core enable not following enable");

  property p_samp_pulse;
    o_sample_hold |-> o_conv_busy ##1 !o_sample_hold;
  endproperty
  a_samp_pulse: assert property (p_samp_pulse) else $error("sample pulse malformed");

  property p_right_high;
    i_rd && i_addr == `SAC_ADDR_RES_HIGH && !input_select_reg[`SAC_SEL_LEFT_ADJ]
      |=> o_rdata[7:2] == 6'h00;
  endproperty
  a_right_high: assert property (p_right_high) else $error("right adjust high byte wrong");
endmodule

// ==== sac_core_model.sv ====
`timescale 1ns/1ns
module sac_core_model
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_core_enable,
  input wire logic [1:0] i_channel_select,
  input wire logic [1:0] i_reference_select,
  input wire logic i_sample_hold,
  output logic [9:0] o_core_result
);
  logic [9:0] held;
  logic live;
  // Code marks channel and reference; scrambled once powered down
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      held <= 10'h000;
      live <= 1'b0;
    end
    else if (i_sample_hold)
    begin
      held <= {i_channel_select, 6'h25, i_reference_select};
      live <= 1'b1;
    end
    else if (!i_core_enable)
      live <= 1'b0;
  end
  assign o_core_result = live ? held : ~held;
endmodule

// ==== tb.sv ====
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_trig = 8'h00;
  logic i_sleep_conv_mode = 1'b0;
  logic i_cpu_halted = 1'b0;
  logic [9:0] core_result;
  logic [7:0] o_rdata;
  logic core_enable, core_init, sample_hold, busy, flag;
  logic [1:0] chan, refsel;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  int samp, len;
  logic [7:0] rv, hi, lo;

  sac_conv_ctrl sac_conv_ctrl_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_trig(i_trig),
    .i_sleep_conv_mode(i_sleep_conv_mode), .i_cpu_halted(i_cpu_halted),
    .i_core_result(core_result), .o_core_enable(core_enable), .o_core_init(core_init),
    .o_channel_select(chan), .o_reference_select(refsel), .o_sample_hold(sample_hold),
    .o_conv_busy(busy), .o_conversion_done_flag(flag));
  sac_core_model sac_core_model_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_core_enable(core_enable), .i_channel_select(chan), .i_reference_select(refsel),
    .i_sample_hold(sample_hold), .o_core_result(core_result));

  always #2 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    #1;
    while (busy !== v && n < 1000)
    begin
      @(posedge i_clk_sys);
      #1 n++;
    end
    `CHK(busy, v)
  endtask

  // Busy length and sample pulse position, in system cycles from busy rise
  task automatic measure();
    wait_busy(1'b1);
    samp = -1;
    len = 0;
    while (busy === 1'b1 && len < 1000)
    begin
      if (sample_hold === 1'b1)
        samp = len;
      len++;
      @(posedge i_clk_sys);
      #1;
    end
  endtask

  // Reads low byte first so both bytes belong to one conversion
  task automatic chk_res(input logic [1:0] ch, input logic [1:0] rf, input logic left);
    logic [9:0] r;
    r = {ch, 6'h25, rf};
    rd(3'h3, lo);
    rd(3'h4, hi);
    `CHK({hi, lo}, left ? {r, 6'h00} : {6'h00, r})
  endtask

  task automatic t_reset();
    `CHK(core_init, 1'b1)
    wr(3'h5, 8'hFF);
    for (int a = 0; a < 6; a++)
    begin
      rd(a[2:0], rv);
      `CHK(rv, 8'h00)
    end
    $display("[DONE] reset values");
  endtask

  task automatic t_disabled();
    wr(3'h0, 8'h03);
    wr(3'h1, 8'h40);
    repeat (20) @(posedge i_clk_sys);
    #1 `CHK(busy, 1'b0)
    `CHK(chan, 2'h0)
    `CHK(core_enable, 1'b0)
    $display("[DONE] disabled");
  endtask

  task automatic t_first();
    wr(3'h0, 8'h41);
    wr(3'h1, 8'hC0);
    measure();
    `CHK(samp, 27)
    `CHK(len, 50)
    `CHK(flag, 1'b1)
    `CHK(core_init, 1'b0)
    rd(3'h1, rv);
    `CHK(rv[6], 1'b0)
    chk_res(2'h1, 2'h1, 1'b0);
    wr(3'h1, 8'hD0);
    measure();
    `CHK(samp, 3)
    `CHK(len, 26)
    $display("[DONE] first and normal timing");
  endtask

  task automatic t_chan_lock();
    wr(3'h0, 8'h21);
    wr(3'h1, 8'hD0);
    wait_busy(1'b1);
    wr(3'h0, 8'h23);
    `CHK(chan, 2'h1)
    wait_busy(1'b0);
    chk_res(2'h1, 2'h0, 1'b1);
    `CHK(chan, 2'h3)
    rd(3'h3, rv);
    wr(3'h1, 8'hD0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    `CHK(flag, 1'b1)
    rd(3'h4, rv);
    `CHK(rv, 8'h65)
    chk_res(2'h1, 2'h0, 1'b1);
    wr(3'h1, 8'hD0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk_res(2'h3, 2'h0, 1'b1);
    $display("[DONE] channel change and result lock");
  endtask

  task automatic t_auto();
    wr(3'h2, 8'h01);
    wr(3'h1, 8'hB0);
    @(posedge i_clk_sys);
    i_trig <= 8'h02;
    measure();
    `CHK(samp, 4)
    `CHK(len, 27)
    repeat (40) @(posedge i_clk_sys);
    #1 `CHK(busy, 1'b0)
    i_trig <= 8'h00;
    @(posedge i_clk_sys);
    i_trig <= 8'h02;
    wait_busy(1'b1);
    @(posedge i_clk_sys);
    i_trig <= 8'h00;
    @(posedge i_clk_sys);
    i_trig <= 8'h02;
    rd(3'h1, rv);
    `CHK(rv[6], 1'b1)
    wait_busy(1'b0);
    repeat (40) @(posedge i_clk_sys);
    #1 `CHK(busy, 1'b0)
    wr(3'h1, 8'hF0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    i_trig <= 8'h00;
    $display("[DONE] auto trigger");
  endtask

  // Busy never drops while free running, so time sample pulse to sample pulse
  task automatic t_free();
    int n;
    wr(3'h2, 8'h00);
    wr(3'h1, 8'hE0);
    wait_busy(1'b1);
    n = 0;
    while (sample_hold !== 1'b1 && n < 1000)
    begin
      @(posedge i_clk_sys);
      #1 n++;
    end
    n = 0;
    do
    begin
      @(posedge i_clk_sys);
      #1 n++;
    end
    while (sample_hold !== 1'b1 && n < 1000);
    `CHK(n, 26)
    `CHK(busy, 1'b1)
    rd(3'h1, rv);
    `CHK(rv[6], 1'b1)
    wr(3'h1, 8'h00);
    #1 `CHK(busy, 1'b0)
    `CHK(core_init, 1'b1)
    $display("[DONE] free running");
  endtask

  // Divider select 1 halves the converter clock, so first-run timing doubles
  task automatic t_div();
    wr(3'h1, 8'hC1);
    measure();
    `CHK(samp, 54)
    `CHK(len, 100)
    $display("[DONE] divider");
  endtask

  task automatic t_sleep();
    wr(3'h1, 8'h98);
    i_sleep_conv_mode <= 1'b1;
    @(posedge i_clk_sys);
    i_cpu_halted <= 1'b1;
    wait_busy(1'b1);
    wait_busy(1'b0);
    `CHK(flag, 1'b1)
    i_cpu_halted <= 1'b0;
    i_sleep_conv_mode <= 1'b0;
    $display("[DONE] sleep start");
  endtask

  initial
  begin
    repeat (5) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    t_reset();
    t_disabled();
    t_first();
    t_chan_lock();
    t_auto();
    t_free();
    t_div();
    t_sleep();
    give_verdict();
  end
endmodule
